// *** verilog/pmp_pkg.sv ***
/*
  Constants, register map and types for the PHY management poller.
  Assumes a single 200 MHz clock and a synchronous active-high reset.
*/
// Contract
// RL1 - Management clock from divided peripheral clock
// RL2 - Enable and divisor share one control register
// RL3 - Control bit omits frame preamble
// RL4 - Enabled engine polls all 32 addresses
// RL5 - Readable presence map updated while polling
// RL6 - Readable link map per PHY
// RL7 - Selected PHY link changes set flag
// RL8 - Link change flag sticky until cleared
// RL9 - Write one clears link change flag
// RL10 - Access and link interrupt enables
// RL11 - Maps valid after one full pass
// RL12 - Software isolates all other present PHYs
// RL13 - Software resets PHY, gives up after 5000
// RL14 - Link good needs PHY and map
// RL15 - Supervise from half-second timer
// RL16 - Access command with go until done
// RL17 - Access reports PHY acknowledge
// RL18 - Map bit n is PHY address n
// RL19 - Disabled engine stays idle
package pmp_pkg;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_CONTROL     = 4'h0;
  localparam logic [ADDR_W-1:0] REG_ALIVE       = 4'h1;
  localparam logic [ADDR_W-1:0] REG_LINK        = 4'h2;
  localparam logic [ADDR_W-1:0] REG_LINK_CHANGE = 4'h3;
  localparam logic [ADDR_W-1:0] REG_ACC_STATUS  = 4'h4;
  localparam logic [ADDR_W-1:0] REG_ACC_MASK    = 4'h5;
  localparam logic [ADDR_W-1:0] REG_ACC_MASKCLR = 4'h6;
  localparam logic [ADDR_W-1:0] REG_ACCESS      = 4'h7;
  localparam logic [ADDR_W-1:0] REG_PHY_SELECT  = 4'h8;
  // Control register fields
  localparam int CTL_DIV_LSB   = 0;
  localparam int DIV_W         = 16;
  localparam int CTL_NOPRE_BIT = 20;
  localparam int CTL_EN_BIT    = 30;
  localparam logic [DIV_W-1:0] DIV_RESET = 16'h00FF;
  // Access command fields
  localparam int ACC_DATA_LSB  = 0;
  localparam int ACC_PHY_LSB   = 16;
  localparam int ACC_REG_LSB   = 21;
  localparam int ACC_ACK_BIT   = 29;
  localparam int ACC_WR_BIT    = 30;
  localparam int ACC_GO_BIT    = 31;
  // Select register fields
  localparam int SEL_LINKIE_BIT = 6;
  localparam int NUM_PHY        = 32;
  localparam int PHY_W          = 5;
  localparam logic [PHY_W-1:0] PHY_LAST = 5'h1F;
  // PHY basic status register and its link bit
  localparam logic [4:0] PHY_STATUS_REG = 5'h01;
  localparam int PHY_LINK_BIT = 2;
  // Frame shape
  localparam int PRE_BITS   = 32;
  localparam int FRAME_BITS = 32;
  localparam int CNT_W      = 6;
  localparam logic [1:0] ST_CODE = 2'b01;
  localparam logic [1:0] OP_RD   = 2'b10;
  localparam logic [1:0] OP_WR   = 2'b01;
  localparam int TA_BIT_POS = 17;
  // Timing: peripheral clock is CPU clock over four, cycle of ours is 5 ns
  localparam int CLK_NS        = 5;
  localparam int PCLK_PRESCALE = 4;
  localparam int READ_MAX_US   = 50;

  typedef enum logic [1:0] {
    PMP_IDLE  = 2'b00,
    PMP_PRE   = 2'b01,
    PMP_FRAME = 2'b10
  } pmp_state_t;
endpackage

// *** verilog/pmp_frame_if.sv ***
/*
  Link between the poller core and the serial frame engine.
  Assumes both ends share the single system clock.
*/
`timescale 1ns/1ps
interface pmp_frame_if;
  import pmp_pkg::*;
  logic             start;
  logic             write;
  logic             skipPre;
  logic [PHY_W-1:0] phyAddr;
  logic [4:0]       regAddr;
  logic [15:0]      wrData;
  logic             busy;
  logic             done;
  logic             ack;
  logic [15:0]      rdData;
  modport core   (output start, write, skipPre, phyAddr, regAddr, wrData,
                  input busy, done, ack, rdData);
  modport engine (input start, write, skipPre, phyAddr, regAddr, wrData,
                  output busy, done, ack, rdData);
endinterface

// *** verilog/pmp_frame_engine.sv ***
/*
  Serial management frame engine: preamble, start, op, addresses,
  turnaround and 16 data bits. Assumes a one-cycle bit enable.
*/
`timescale 1ns/1ps
module pmp_frame_engine
  import pmp_pkg::*;
(
  input  wire logic     clock,
  input  wire logic     rst,
  input  wire logic     bitTick,
  input  wire logic     halfTick,
  input  wire logic     mdIn,
  pmp_frame_if.engine   fr,
  output      logic     mdc,
  output      logic     mdOut,
  output      logic     mdOe
);
  pmp_state_t       state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [31:0]      sh_q, sh_d;
  logic [15:0]      rd_q, rd_d;
  logic             wr_q, wr_d, ack_q, ack_d, mdc_q, mdc_d, oe_q, oe_d;
  logic             done_q, done_d;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    sh_d    = sh_q;
    rd_d    = rd_q;
    wr_d    = wr_q;
    ack_d   = ack_q;
    mdc_d   = mdc_q;
    oe_d    = oe_q;
    done_d  = 1'b0;
    case (state_q)
      PMP_IDLE: begin
        mdc_d = 1'b0;
        oe_d  = 1'b0;
        if (fr.start) begin
          wr_d  = fr.write;
          sh_d  = {ST_CODE, fr.write ? OP_WR : OP_RD, fr.phyAddr, fr.regAddr,
                   2'b10, fr.write ? fr.wrData : 16'h0000};
          cnt_d = '0;
          oe_d  = 1'b1;
          // Preamble skipped whenever the control bit sets skipPre (see RL3)
          state_d = fr.skipPre ? PMP_FRAME : PMP_PRE;
        end
      end
      PMP_PRE: begin
        if (halfTick) mdc_d = 1'b1;
        // A tick before the first rise is skipped, so no bit goes unclocked
        if (bitTick && mdc_q) begin
          mdc_d = 1'b0;
          cnt_d = cnt_q + 1'b1;
          if (cnt_q == CNT_W'(PRE_BITS - 1)) begin
            cnt_d   = '0;
            state_d = PMP_FRAME;
          end
        end
      end
      PMP_FRAME: begin
        if (halfTick) begin
          mdc_d = 1'b1;
          // Acknowledge is PHY pulling line low in second turnaround bit
          if (!wr_q && cnt_q == CNT_W'(TA_BIT_POS - 2)) ack_d = ~mdIn; // see RL17
          if (!wr_q && cnt_q >= CNT_W'(TA_BIT_POS - 1)) rd_d = {rd_q[14:0], mdIn};
        end
        if (bitTick && mdc_q) begin
          mdc_d = 1'b0;
          sh_d  = {sh_q[30:0], 1'b0};
          cnt_d = cnt_q + 1'b1;
          if (!wr_q && cnt_q == CNT_W'(TA_BIT_POS - 4)) oe_d = 1'b0;
          if (cnt_q == CNT_W'(FRAME_BITS - 1)) begin
            oe_d    = 1'b0;
            done_d  = 1'b1;
            state_d = PMP_IDLE;
          end
        end
      end
      default: state_d = PMP_IDLE;
    endcase
    if (state_q == PMP_IDLE && fr.start && fr.write) ack_d = 1'b1;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= PMP_IDLE;
      cnt_q   <= '0;
      sh_q    <= '0;
      rd_q    <= '0;
      wr_q    <= 1'b0;
      ack_q   <= 1'b0;
      mdc_q   <= 1'b0;
      oe_q    <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      sh_q    <= sh_d;
      rd_q    <= rd_d;
      wr_q    <= wr_d;
      ack_q   <= ack_d;
      mdc_q   <= mdc_d;
      oe_q    <= oe_d;
      done_q  <= done_d;
    end
  end

  assign mdc       = mdc_q;
  assign mdOut     = (state_q == PMP_PRE) ? 1'b1 : sh_q[31];
  assign mdOe      = oe_q;
  assign fr.busy   = (state_q != PMP_IDLE);
  assign fr.done   = done_q;
  assign fr.ack    = ack_q;
  assign fr.rdData = rd_q;
endmodule

// *** verilog/pmp_clock_divider.sv ***
/*
  Management bit-rate divider: peripheral prescale then programmable divisor.
  Assumes divisor changes only while the engine is idle.
*/
`timescale 1ns/1ps
module pmp_clock_divider
  import pmp_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             run,
  input  wire logic [DIV_W-1:0] divisor,
  output      logic             bitTick,
  output      logic             halfTick
);
  localparam int PRE_W = 2;
  logic [PRE_W-1:0] pre_q, pre_d;
  logic [DIV_W:0]   cnt_q, cnt_d;
  logic             pclkEn;
  logic [DIV_W:0]   period;

  // Divisor counts peripheral clocks per bit, zero treated as one (see RL1)
  assign period = (divisor == '0) ? (DIV_W+1)'(1) : {1'b0, divisor};
  assign pclkEn = (pre_q == PRE_W'(PCLK_PRESCALE - 1));

  always_comb begin
    pre_d = run ? pre_q + 1'b1 : '0;
    cnt_d = cnt_q;
    if (!run) cnt_d = '0; // see RL19
    else if (pclkEn) cnt_d = (cnt_q >= period - 1'b1) ? '0 : cnt_q + 1'b1;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pre_q <= '0;
      cnt_q <= '0;
    end else begin
      pre_q <= pre_d;
      cnt_q <= cnt_d;
    end
  end

  assign bitTick  = run && pclkEn && (cnt_q >= period - 1'b1);
  // Rise one half period before the bit tick, never on the same clock; a
  // one-clock period rises mid-prescale instead (see RL1)
  assign halfTick = run && ((period == (DIV_W+1)'(1))
                            ? (pre_q == PRE_W'(PCLK_PRESCALE/2 - 1))
                            : (pclkEn && cnt_q == (period >> 1) - 1'b1));
endmodule

// *** verilog/phy_management_poller.sv ***
/*
  PHY management poller top: register file, polling scheduler, user
  access arbitration, link change flag and interrupt. Assumes a master
  that holds one-cycle strobes and reads data the cycle after a read.
*/
`timescale 1ns/1ps
module phy_management_poller
  import pmp_pkg::*;
#(
  parameter int NPHY = NUM_PHY
)(
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic [pmp_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [31:0]           regWrData,
  input  wire logic                  regWrite,
  input  wire logic                  regRead,
  output      logic [31:0]           regRdData,
  output      logic                  irq,
  output      logic                  mdc,
  input  wire logic                  mdioIn,
  output      logic                  mdioOut,
  output      logic                  mdioOe
);
  logic             en_q, en_d, nopre_q, nopre_d;
  logic [DIV_W-1:0] div_q, div_d;
  logic [NPHY-1:0]  alive_q, alive_d, link_q, link_d;
  logic             chg_q, chg_d;
  logic [PHY_W-1:0] sel_q, sel_d, poll_q, poll_d;
  logic             linkIe_q, linkIe_d;
  logic             go_q, go_d, uwr_q, uwr_d, uack_q, uack_d;
  logic [4:0]       ureg_q, ureg_d;
  logic [PHY_W-1:0] uphy_q, uphy_d;
  logic [15:0]      udata_q, udata_d;
  logic             accDone_q, accDone_d, accMask_q, accMask_d;
  logic             userOwn_q, userOwn_d, start_q, start_d;
  logic [31:0]      rd_q, rd_d;
  logic [2:0]       in_q;
  logic             mdIn, bitTick, halfTick;

  pmp_frame_if fr();

  // Three stages on the pin, a change counts once last two agree.
  // Agreement is used unregistered: at divisor 2 a bit moved at the fall
  // is sampled four clocks later; smaller divisors read too early
  logic       mdInHeld_q, mdInHeld_d, engRst;
  logic [2:0] in_d;
  always_comb begin
    in_d       = {in_q[1:0], mdioIn};
    mdInHeld_d = (in_q[2] == in_q[1]) ? in_q[1] : mdInHeld_q;
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      in_q       <= 3'b111;
      mdInHeld_q <= 1'b1;
    end else begin
      in_q       <= in_d;
      mdInHeld_q <= mdInHeld_d;
    end
  end
  assign mdIn = mdInHeld_d;
  // Disabling aborts a frame in flight so the bus clock parks low (see RL19)
  assign engRst = rst || !en_q;

  pmp_clock_divider u_div (
    .clock    (clock),
    .rst      (rst),
    .run      (en_q),
    .divisor  (div_q),
    .bitTick  (bitTick),
    .halfTick (halfTick)
  );

  pmp_frame_engine u_frame (
    .clock    (clock),
    .rst      (engRst),
    .bitTick  (bitTick),
    .halfTick (halfTick),
    .mdIn     (mdIn),
    .fr       (fr),
    .mdc      (mdc),
    .mdOut    (mdioOut),
    .mdOe     (mdioOe)
  );

  logic wrCtl, wrChg, wrMask, wrMaskClr, wrAcc, wrSel, wrAccSt;
  logic pollAlive, pollLink;
  assign wrCtl     = regWrite && regAddr == REG_CONTROL;
  assign wrChg     = regWrite && regAddr == REG_LINK_CHANGE;
  assign wrAccSt   = regWrite && regAddr == REG_ACC_STATUS;
  assign wrMask    = regWrite && regAddr == REG_ACC_MASK;
  assign wrMaskClr = regWrite && regAddr == REG_ACC_MASKCLR;
  assign wrAcc     = regWrite && regAddr == REG_ACCESS;
  assign wrSel     = regWrite && regAddr == REG_PHY_SELECT;
  assign pollAlive = fr.ack;
  assign pollLink  = fr.ack && fr.rdData[PHY_LINK_BIT];

  always_comb begin
    en_d      = en_q;
    nopre_d   = nopre_q;
    div_d     = div_q;
    alive_d   = alive_q;
    link_d    = link_q;
    chg_d     = chg_q;
    sel_d     = sel_q;
    linkIe_d  = linkIe_q;
    poll_d    = poll_q;
    go_d      = go_q;
    uwr_d     = uwr_q;
    uack_d    = uack_q;
    ureg_d    = ureg_q;
    uphy_d    = uphy_q;
    udata_d   = udata_q;
    accDone_d = accDone_q;
    accMask_d = accMask_q;
    userOwn_d = userOwn_q;
    start_d   = 1'b0;
    if (wrCtl) begin
      // One write sets enable, preamble option and divisor (see RL2)
      en_d    = regWrData[CTL_EN_BIT];
      nopre_d = regWrData[CTL_NOPRE_BIT];
      div_d   = regWrData[CTL_DIV_LSB +: DIV_W];
    end
    if (wrSel) begin
      sel_d    = regWrData[PHY_W-1:0]; // see RL7
      linkIe_d = regWrData[SEL_LINKIE_BIT]; // see RL10
    end
    if (wrMask && regWrData[0]) accMask_d = 1'b1; // see RL10
    if (wrMaskClr && regWrData[0]) accMask_d = 1'b0;
    if (wrChg && regWrData[0]) chg_d = 1'b0; // see RL9
    if (wrAccSt && regWrData[0]) accDone_d = 1'b0;
    if (wrAcc && !go_q && regWrData[ACC_GO_BIT]) begin
      go_d    = 1'b1; // see RL16
      uwr_d   = regWrData[ACC_WR_BIT];
      ureg_d  = regWrData[ACC_REG_LSB +: 5];
      uphy_d  = regWrData[ACC_PHY_LSB +: PHY_W];
      udata_d = regWrData[ACC_DATA_LSB +: 16];
    end
    // Frame completion: user access or poll result
    if (fr.done) begin
      if (userOwn_q) begin
        go_d      = 1'b0;
        uack_d    = fr.ack; // see RL17
        accDone_d = 1'b1;
        if (!uwr_q) udata_d = fr.rdData;
        userOwn_d = 1'b0;
      end else begin
        // Bit n tracks PHY address n, one bit per frame (see RL11, RL18)
        alive_d[poll_q] = pollAlive; // see RL5
        link_d[poll_q]  = pollLink; // see RL6
        if (poll_q == sel_q && link_q[poll_q] != pollLink) chg_d = 1'b1; // see RL7
        poll_d = (poll_q == PHY_W'(NPHY - 1)) ? '0 : poll_q + 1'b1; // see RL4
      end
    end
    // User access takes the bus ahead of the next poll frame
    if (en_q && !fr.busy && !start_q && !fr.done) begin // see RL19
      start_d   = 1'b1;
      userOwn_d = go_q;
    end
  end

  assign fr.start   = start_q;
  assign fr.skipPre = nopre_q;
  assign fr.write   = userOwn_q && uwr_q;
  assign fr.phyAddr = userOwn_q ? uphy_q : poll_q;
  assign fr.regAddr = userOwn_q ? ureg_q : PHY_STATUS_REG;
  assign fr.wrData  = udata_q;

  always_comb begin
    rd_d = 32'h0000_0000;
    if (regRead) begin
      case (regAddr)
        REG_CONTROL: begin
          rd_d[CTL_EN_BIT]               = en_q;
          rd_d[CTL_NOPRE_BIT]            = nopre_q;
          rd_d[CTL_DIV_LSB +: DIV_W]     = div_q;
        end
        REG_ALIVE:       rd_d = 32'(alive_q);
        REG_LINK:        rd_d = 32'(link_q);
        REG_LINK_CHANGE: rd_d[0] = chg_q;
        REG_ACC_STATUS:  rd_d[0] = accDone_q;
        REG_ACC_MASK:    rd_d[0] = accMask_q;
        REG_ACC_MASKCLR: rd_d[0] = accMask_q;
        REG_ACCESS: begin
          rd_d[ACC_GO_BIT]            = go_q;
          rd_d[ACC_WR_BIT]            = uwr_q;
          rd_d[ACC_ACK_BIT]           = uack_q;
          rd_d[ACC_REG_LSB +: 5]      = ureg_q;
          rd_d[ACC_PHY_LSB +: PHY_W]  = uphy_q;
          rd_d[ACC_DATA_LSB +: 16]    = udata_q;
        end
        REG_PHY_SELECT: begin
          rd_d[PHY_W-1:0]      = sel_q;
          rd_d[SEL_LINKIE_BIT] = linkIe_q;
        end
        default: rd_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      en_q      <= 1'b0;
      nopre_q   <= 1'b0;
      div_q     <= DIV_RESET;
      alive_q   <= '0;
      link_q    <= '0;
      chg_q     <= 1'b0;
      sel_q     <= '0;
      linkIe_q  <= 1'b0;
      poll_q    <= '0;
      go_q      <= 1'b0;
      uwr_q     <= 1'b0;
      uack_q    <= 1'b0;
      ureg_q    <= '0;
      uphy_q    <= '0;
      udata_q   <= '0;
      accDone_q <= 1'b0;
      accMask_q <= 1'b0;
      userOwn_q <= 1'b0;
      start_q   <= 1'b0;
      rd_q      <= '0;
    end else begin
      en_q      <= en_d;
      nopre_q   <= nopre_d;
      div_q     <= div_d;
      alive_q   <= alive_d;
      link_q    <= link_d;
      chg_q     <= chg_d; // see RL8
      sel_q     <= sel_d;
      linkIe_q  <= linkIe_d;
      poll_q    <= poll_d;
      go_q      <= go_d;
      uwr_q     <= uwr_d;
      uack_q    <= uack_d;
      ureg_q    <= ureg_d;
      uphy_q    <= uphy_d;
      udata_q   <= udata_d;
      accDone_q <= accDone_d;
      accMask_q <= accMask_d;
      userOwn_q <= userOwn_d;
      start_q   <= start_d;
      rd_q      <= rd_d;
    end
  end

  assign regRdData = rd_q;
  assign irq       = (chg_q && linkIe_q) || (accDone_q && accMask_q); // see RL10
endmodule

// *** verification/pmp_props.sv ***
/* Checker for the PHY management poller, bound to its top ports.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module pmp_props
  import pmp_pkg::*;
#(
  parameter int NPHY = NUM_PHY
)(
  input wire logic                       clock,
  input wire logic                       rst,
  input wire logic [pmp_pkg::ADDR_W-1:0] regAddr,
  input wire logic [31:0]                regWrData,
  input wire logic                       regWrite,
  input wire logic                       regRead,
  input wire logic [31:0]                regRdData,
  input wire logic                       irq,
  input wire logic                       mdc,
  input wire logic                       mdioIn,
  input wire logic                       mdioOut,
  input wire logic                       mdioOe
);
  logic             enQ, noPreQ, ieQ, maskQ;
  logic [DIV_W-1:0] divQ;
  logic [17:0]      gapQ, minGap;
  // Zero divisor behaves as one
  assign minGap = (divQ == '0) ? 18'h00004 : {divQ, 2'b00};
  always_ff @(posedge clock) begin
    if (rst) begin
      enQ    <= 1'b0;
      noPreQ <= 1'b0;
      ieQ    <= 1'b0;
      maskQ  <= 1'b0;
      divQ   <= DIV_RESET;
      gapQ   <= 18'h3FFFF;
    end else begin
      if ($rose(mdc)) gapQ <= 18'h00001;
      else if (gapQ != 18'h3FFFF) gapQ <= gapQ + 18'h00001;
      if (regWrite && regAddr == REG_CONTROL) begin
        enQ    <= regWrData[CTL_EN_BIT];
        noPreQ <= regWrData[CTL_NOPRE_BIT];
        divQ   <= regWrData[DIV_W-1:0];
      end
      if (regWrite && regAddr == REG_PHY_SELECT) ieQ <= regWrData[SEL_LINKIE_BIT];
      if (regWrite && regAddr == REG_ACC_MASK && regWrData[0]) maskQ <= 1'b1;
      if (regWrite && regAddr == REG_ACC_MASKCLR && regWrData[0]) maskQ <= 1'b0;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_preamble; mdioOut [*8]; endsequence
  sequence s_goWrite; regWrite && regAddr == REG_ACCESS && regWrData[ACC_GO_BIT]; endsequence
  sequence s_goRead; regRead && regAddr == REG_ACCESS; endsequence
  property p_idle_off; (!enQ) [*3] |-> !mdc; endproperty
  property p_bit_period; $rose(mdc) |-> gapQ >= minGap; endproperty
  property p_irq_masked; !ieQ && !maskQ |-> !irq; endproperty
  // Option as it stood when the frame was launched, one clock before
  property p_preamble; $rose(mdioOe) && !$past(noPreQ) |-> s_preamble; endproperty
  property p_no_preamble; $rose(mdioOe) && $past(noPreQ) |-> !mdioOut; endproperty
  property p_read_quiet; !$past(regRead) |-> regRdData == 32'h0; endproperty
  property p_go_held; s_goWrite ##1 s_goRead |=> regRdData[ACC_GO_BIT]; endproperty
  property p_ctl_read;
    regRead && regAddr == REG_CONTROL |=> regRdData[DIV_W-1:0] == divQ
      && regRdData[CTL_EN_BIT] == enQ && regRdData[CTL_NOPRE_BIT] == noPreQ;
  endproperty
  a_idle_off: assert property (p_idle_off)
    else $error("mdc toggles while disabled");
  a_bit_period: assert property (p_bit_period)
    else $error("mdc bit period too short");
  a_irq_masked: assert property (p_irq_masked)
    else $error("irq with all enables clear");
  a_preamble: assert property (p_preamble)
    else $error("preamble missing");
  a_no_preamble: assert property (p_no_preamble)
    else $error("preamble sent although omitted");
  a_read_quiet: assert property (p_read_quiet)
    else $error("read data outside read slot");
  a_go_held: assert property (p_go_held)
    else $error("go cleared too early");
  a_ctl_read: assert property (p_ctl_read)
    else $error("control readback differs");
endmodule

bind phy_management_poller pmp_props #(.NPHY(NPHY)) u_props (.clock(clock), .rst(rst),
  .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
  .regRdData(regRdData), .irq(irq), .mdc(mdc), .mdioIn(mdioIn), .mdioOut(mdioOut),
  .mdioOe(mdioOe));

// *** verification/pmp_phy_model.sv ***
/* Behavioural set of PHYs on the management bus.
   Assumes the bench resolves the shared line with a pull-up. */
`timescale 1ns/1ps
module pmp_phy_model
  import pmp_pkg::*;
(
  input  wire logic        mdc,
  input  wire logic        mdioLine,
  input  wire logic [31:0] present,
  input  wire logic [31:0] linkUp,
  output      logic        phyOut,
  output      logic        phyOe
);
  logic        inFrame = 1'b0;
  logic        prevBit = 1'b1;
  int          cnt = 0;
  logic [11:0] hdr = '0;
  logic [15:0] wrShift = '0;
  logic [15:0] scratch [32];
  logic [15:0] rdWord;
  initial begin
    phyOut = 1'b1;
    phyOe = 1'b0;
    foreach (scratch[i]) scratch[i] = '0;
  end
  // Status register carries link state
  assign rdWord = (hdr[4:0] == PHY_STATUS_REG) ? {13'h0, linkUp[hdr[9:5]], 2'b00}
                                               : scratch[hdr[4:0]];
  always @(posedge mdc) begin
    if (!inFrame) begin
      if (!prevBit && mdioLine) begin
        inFrame = 1'b1;
        cnt = 0;
      end
      prevBit = mdioLine;
    end else begin
      if (cnt < 12) hdr = {hdr[10:0], mdioLine};
      else if (cnt >= 14) wrShift = {wrShift[14:0], mdioLine};
      cnt = cnt + 1;
      if (cnt == 30) begin
        inFrame = 1'b0;
        prevBit = 1'b1;
        if (hdr[11:10] == OP_WR && present[hdr[9:5]]) scratch[hdr[4:0]] = wrShift;
      end
    end
  end
  // Drive after the falling edge so the station sees settled bits
  always @(negedge mdc) begin
    if (inFrame && hdr[11:10] == OP_RD && present[hdr[9:5]] && cnt >= 13) begin
      phyOe <= 1'b1;
      phyOut <= (cnt == 13) ? 1'b0 : rdWord[29-cnt];
    end else begin
      phyOe <= 1'b0;
      phyOut <= 1'b1;
    end
  end
endmodule

// *** verification/phy_management_poller_tb_top.sv ***
/* Self-checking bench for the PHY management poller.
   Assumes the PHY model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
module phy_management_poller_tb_top;
  import pmp_pkg::*;
  logic              clock = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [31:0]       regWrData = '0;
  logic              regWrite = 1'b0;
  logic              regRead = 1'b0;
  logic [31:0]       regRdData, d;
  logic              irq, mdc, mdioOut, mdioOe, phyOut, phyOe;
  wire               mdioLine;
  logic [31:0]       present = 32'h8000_0021;
  logic [31:0]       linkUp = 32'h8000_0001;
  int                failures = 0;
  int                compares = 0;
  int                rises = 0;
  time               lastRise = 0;
  time               period = 0;
  // Pull-up holds the line high when released
  assign mdioLine = mdioOe ? mdioOut : (phyOe ? phyOut : 1'b1);
  always #2.5 clock = ~clock;
  always @(posedge mdc) begin
    rises++;
    period = $time - lastRise;
    lastRise = $time;
  end
  phy_management_poller #(.NPHY(NUM_PHY)) uut (.clock(clock), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .irq(irq), .mdc(mdc), .mdioIn(mdioLine), .mdioOut(mdioOut), .mdioOe(mdioOe));
  pmp_phy_model phy (.mdc(mdc), .mdioLine(mdioLine), .present(present), .linkUp(linkUp),
    .phyOut(phyOut), .phyOe(phyOe));

  task automatic report_and_stop();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // All bus tasks start and end right after a rising edge
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] v);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1 v = regRdData;
    @(posedge clock);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic chkIrq(input logic e);
    #1 check("irq", {31'h0, irq}, {31'h0, e});
    @(posedge clock);
  endtask
  task automatic waitBit(input logic [ADDR_W-1:0] a, input int b, input logic v);
    // Bounded re-polling at a coarse period
    for (int i = 0; i < 100; i++) begin
      rd(a, d);
      if (d[b] === v) return;
      idle(250);
    end
    check("awaited bit", {31'h0, d[b]}, {31'h0, v});
  endtask
  task automatic acc(input logic [31:0] cmd);
    wr(REG_ACCESS, cmd);
    waitBit(REG_ACCESS, ACC_GO_BIT, 1'b0);
    rd(REG_ACCESS, d);
  endtask

  task automatic t_reset();
    rd(REG_CONTROL, d);
    check("control", d, {16'h0, DIV_RESET});
    wr(4'hF, 32'hFFFF_FFFF);
    rd(4'hF, d);
    check("unmapped", d, 32'h0);
    idle(200);
    check("mdc idle", 32'(rises), 32'h0);
    $display("test reset done");
  endtask
  task automatic t_poll();
    wr(REG_CONTROL, 32'h4010_0002);
    rd(REG_CONTROL, d);
    check("control", d, 32'h4010_0002);
    repeat (3) @(posedge mdc);
    @(posedge clock);
    check("mdc period", 32'(period), 32'(PCLK_PRESCALE * 2 * CLK_NS));
    waitBit(REG_ALIVE, 31, 1'b1);
    rd(REG_ALIVE, d);
    check("alive", d, present);
    rd(REG_LINK, d);
    check("link", d, linkUp);
    present[31] <= 1'b0;
    waitBit(REG_ALIVE, 31, 1'b0);
    rd(REG_LINK, d);
    check("link gone", d, 32'h0000_0001);
    $display("test poll done");
  endtask
  task automatic t_link();
    wr(REG_PHY_SELECT, 32'h0000_0045);
    idle(9000);
    wr(REG_LINK_CHANGE, 32'h1);
    rd(REG_LINK_CHANGE, d);
    check("change clear", d, 32'h0);
    chkIrq(1'b0);
    linkUp[5] <= 1'b1;
    waitBit(REG_LINK_CHANGE, 0, 1'b1);
    chkIrq(1'b1);
    idle(9000);
    rd(REG_LINK_CHANGE, d);
    check("change sticky", d, 32'h1);
    wr(REG_PHY_SELECT, 32'h0000_0005);
    chkIrq(1'b0);
    wr(REG_LINK_CHANGE, 32'h1);
    $display("test link done");
  endtask
  task automatic t_access();
    wr(REG_ACC_MASK, 32'h1);
    idle(1);
    acc(32'h8025_0000);
    check("status read", d & 32'h2000_FFFF, 32'h2000_0004);
    chkIrq(1'b1);
    wr(REG_ACC_STATUS, 32'h1);
    chkIrq(1'b0);
    acc(32'hC080_1234);
    acc(32'h8080_0000);
    check("written", d & 32'h2000_FFFF, 32'h2000_1234);
    acc(32'h8023_0000);
    check("no ack", d & 32'h2000_0000, 32'h0);
    wr(REG_ACC_MASKCLR, 32'h1);
    chkIrq(1'b0);
    $display("test access done");
  endtask
  task automatic t_off();
    wr(REG_CONTROL, 32'h4000_0002);
    idle(1500);
    wr(REG_CONTROL, 32'h0000_0002);
    idle(10);
    d = 32'(rises);
    idle(600);
    check("mdc stopped", 32'(rises), d);
    $display("test disable done");
  endtask

  initial begin
    idle(12);
    rst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_poll();
    t_link();
    t_access();
    t_off();
    report_and_stop();
  end
  // Tests need roughly 40k cycles
  initial begin
    idle(90000);
    failures++;
    report_and_stop();
  end
endmodule
